// *** rtl/did_pkg.sv ***
// Package for the display instruction decoder.
// Assumes a single 100 MHz clock domain and byte-wide host transfers.
package did_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000; // Core clock rate
  localparam int EXEC_NS = 666; // Instruction execution time
  localparam int EXEC_CYC = (EXEC_NS * 100 + 999) / 1000; // Rounded up
  localparam int BLINK_HZ = 1; // Blink rate
  localparam int BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ); // Half period

  // ----------------------------------------------------------------
  // Instruction field positions
  // ----------------------------------------------------------------
  localparam int B_INC = 1; // Entry mode: increment
  localparam int B_SHIFT = 0; // Entry mode: display shift
  localparam int B_DISP = 2; // On/off: display
  localparam int B_CURS = 1; // On/off: cursor
  localparam int B_BLINK = 0; // On/off: blink
  localparam int B_SC = 3; // Shift: display with cursor
  localparam int B_RL = 2; // Shift: rightward
  localparam int B_IF = 4; // Function set: eight-bit bus

  // ----------------------------------------------------------------
  // Reset values and glyph mask
  // ----------------------------------------------------------------
  localparam logic [6:0] AC_RST = 7'h00; // Address counter
  localparam logic [1:0] BRIGHT_RST = 2'h0; // Full brightness
  localparam logic [6:0] GLYPH_MASK = 7'h3F; // Six-bit glyph space

  // Decoder state, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } did_state_t;

  // Display control bundle
  typedef struct packed {
    logic disp_on; // Whole display on
    logic cursor_on; // Cursor visible
    logic blink_on; // Blink enabled
  } did_disp_t;

  // Entry mode bundle
  typedef struct packed {
    logic inc; // Increment address counter
    logic shift; // Display shift on write
  } did_entry_t;

endpackage : did_pkg

// *** rtl/did_decoder.sv ***
// Instruction decoder for a character display controller.
// Assumes bytes arrive on the clk domain; pin sync happens upstream.
//
// Function
// - Entry mode sets increment or decrement
// - Entry bit zero picks display shift
// - Display shift on text writes runs opposite cursor direction
// - Text reads always move the cursor
// - Glyph RAM accesses always move cursor
// - Display shift moves all lines together
// - On/off sets display, cursor, blink
// - Display off disables power converter
// - Blink alternates normal and all dots
// - Blink runs near one hertz, even
// - Shift instruction moves without RAM access
// - Bit three selects display with cursor
// - Bit two selects right, else left
// - Function set picks bus width
// - Data after function set is brightness
// - Instruction other than function set after function set cancels brightness
// - Brightness codes map full to quarter
// - Glyph address load, six bits
// - Glyph address counter wraps at six bits
// - Text address load, seven bits
// - Status read gives busy and counter
`timescale 1ns/1ps
module did_decoder (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Host byte port
  input wire logic wr_stb,
  input wire logic register_select,
  input wire logic [7:0] wr_data,
  // Host access strobes for RAM reads
  input wire logic rd_stb,
  // Status readback
  output logic [7:0] status_q,
  // Display control outputs
  output did_pkg::did_disp_t disp_q,
  output logic conv_en_q,
  output logic blink_all_q,
  output logic [1:0] bright_q,
  output logic bus8_q,
  // Address and movement
  output logic [6:0] address_counter_q,
  output logic glyph_sel_q,
  output logic shift_pulse_q,
  output logic shift_right_q,
  output logic ram_wr_q,
  output logic ram_rd_q
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  did_pkg::did_state_t state_q; // Executing or idle
  did_pkg::did_entry_t entry_q; // Entry mode
  logic bright_pend_q; // Brightness byte expected next
  logic [9:0] exec_cnt_q; // Execution timer
  logic [26:0] blink_cnt_q; // Blink half-period timer
  logic blink_phase_q; // Blink phase

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire idle = (state_q == did_pkg::ST_IDLE);
  wire take = idle & (wr_stb | rd_stb);
  wire cmd = take & wr_stb & ~register_select;
  wire dat_wr = take & wr_stb & register_select;
  wire dat_rd = take & ~wr_stb & rd_stb & register_select;
  wire is_entry = cmd & (wr_data[7:2] == 6'h01);
  wire is_disp = cmd & (wr_data[7:3] == 5'h01);
  wire is_shift = cmd & (wr_data[7:4] == 4'h1);
  wire is_func = cmd & (wr_data[7:5] == 3'h1);
  wire is_glyph = cmd & (wr_data[7:6] == 2'h1);
  wire is_text = cmd & wr_data[7];
  wire is_bright = dat_wr & bright_pend_q;
  wire ram_acc = (dat_wr & ~bright_pend_q) | dat_rd;
  // Data accesses shift the display only on text writes with shift mode set
  wire acc_shift = dat_wr & ~bright_pend_q & entry_q.shift
    & ~glyph_sel_q;
  wire [6:0] ac_step = entry_q.inc ? 7'h01 : 7'h7F;
  wire [6:0] ac_sum = address_counter_q + ac_step;
  // Glyph space keeps only six bits so it wraps at the top
  wire [6:0] ac_next = glyph_sel_q ? (ac_sum & did_pkg::GLYPH_MASK)
    : ac_sum;
  wire [6:0] sh_step = wr_data[did_pkg::B_RL] ? 7'h01 : 7'h7F;
  wire [6:0] sh_sum = address_counter_q + sh_step;
  wire [6:0] sh_next = glyph_sel_q ? (sh_sum & did_pkg::GLYPH_MASK)
    : sh_sum;
  wire exec_done = (exec_cnt_q == 10'(did_pkg::EXEC_CYC - 1));
  wire blink_wrap = (blink_cnt_q == 27'(did_pkg::BLINK_HALF_CYC - 1));

  // ----------------------------------------------------------------
  // Busy state machine
  // ----------------------------------------------------------------
  // Every accepted byte holds busy for the execution time
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= did_pkg::ST_IDLE;
      exec_cnt_q <= 10'h000;
    end else begin
      unique case (state_q)
        did_pkg::ST_IDLE: begin
          exec_cnt_q <= 10'h000;
          if (take) begin
            state_q <= did_pkg::ST_BUSY;
          end
        end
        did_pkg::ST_BUSY: begin
          exec_cnt_q <= exec_cnt_q + 10'h001;
          if (exec_done) begin
            state_q <= did_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Mode registers
  // ----------------------------------------------------------------
  // Reset defaults: increment, no shift, display off, eight-bit bus
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      entry_q <= '{inc: 1'b1, shift: 1'b0};
      disp_q <= '0;
      bus8_q <= 1'b1;
      bright_q <= did_pkg::BRIGHT_RST;
      bright_pend_q <= 1'b0;
    end else begin
      if (is_entry) begin
        entry_q.inc <= wr_data[did_pkg::B_INC];
        entry_q.shift <= wr_data[did_pkg::B_SHIFT];
      end
      if (is_disp) begin
        disp_q.disp_on <= wr_data[did_pkg::B_DISP];
        disp_q.cursor_on <= wr_data[did_pkg::B_CURS];
        disp_q.blink_on <= wr_data[did_pkg::B_BLINK];
      end
      if (is_func) begin
        bus8_q <= wr_data[did_pkg::B_IF];
      end
      if (is_bright) begin
        bright_q <= wr_data[1:0];
      end
      // Armed by function set, dropped by any other accepted byte
      if (take) begin
        bright_pend_q <= is_func;
      end
    end
  end

  // ----------------------------------------------------------------
  // Address counter and movement
  // ----------------------------------------------------------------
  // Loads win over shift steps, shift steps over plain RAM steps
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      address_counter_q <= did_pkg::AC_RST;
      glyph_sel_q <= 1'b0;
      shift_pulse_q <= 1'b0;
      shift_right_q <= 1'b0;
      ram_wr_q <= 1'b0;
      ram_rd_q <= 1'b0;
    end else begin
      shift_pulse_q <= 1'b0;
      ram_wr_q <= dat_wr & ~bright_pend_q;
      ram_rd_q <= dat_rd;
      if (is_glyph) begin
        address_counter_q <= {1'b0, wr_data[5:0]};
        glyph_sel_q <= 1'b1;
      end else if (is_text) begin
        address_counter_q <= wr_data[6:0];
        glyph_sel_q <= 1'b0;
      end else if (is_shift) begin
        // Cursor moves without any RAM access
        address_counter_q <= sh_next;
        shift_pulse_q <= wr_data[did_pkg::B_SC];
        shift_right_q <= wr_data[did_pkg::B_RL];
      end else if (acc_shift) begin
        // One pulse shifts every line at once
        address_counter_q <= ac_next;
        shift_pulse_q <= 1'b1;
        shift_right_q <= ~entry_q.inc;
      end else if (ram_acc) begin
        address_counter_q <= ac_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // Blink timer and power converter
  // ----------------------------------------------------------------
  // Equal halves of the blink period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      blink_cnt_q <= 27'h0000000;
      blink_phase_q <= 1'b0;
    end else if (blink_wrap) begin
      blink_cnt_q <= 27'h0000000;
      blink_phase_q <= ~blink_phase_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 27'h0000001;
    end
  end

  // Registered outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_en_q <= 1'b0;
      blink_all_q <= 1'b0;
      status_q <= 8'h00;
    end else begin
      conv_en_q <= disp_q.disp_on;
      // Cursor cell shows all dots in the lit phase
      blink_all_q <= disp_q.blink_on & blink_phase_q;
      status_q <= {~idle | take, address_counter_q};
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Mode loads land one edge after the byte is taken
  chk_entry_inc: assert property (
    @(posedge clk) disable iff (rst)
    is_entry |=> entry_q.inc == $past(wr_data[1]))
    else $error("entry increment not loaded");
  chk_entry_shift: assert property (
    @(posedge clk) disable iff (rst)
    is_entry |=> entry_q.shift == $past(wr_data[did_pkg::B_SHIFT]))
    else $error("entry shift mode not loaded");
  chk_disp_load: assert property (
    @(posedge clk) disable iff (rst)
    is_disp |=> disp_q == $past(wr_data[2:0]))
    else $error("display control not loaded");
  chk_func_bus: assert property (
    @(posedge clk) disable iff (rst)
    is_func |=> bus8_q == $past(wr_data[did_pkg::B_IF]))
    else $error("bus width not loaded");
  // Address counter loads and the six-bit glyph wrap
  chk_glyph_load: assert property (
    @(posedge clk) disable iff (rst)
    is_glyph |=> glyph_sel_q
    && address_counter_q == {1'b0, $past(wr_data[5:0])})
    else $error("glyph address not loaded");
  chk_glyph_wrap: assert property (
    @(posedge clk) disable iff (rst)
    glyph_sel_q |-> address_counter_q[6] == 1'b0)
    else $error("glyph address beyond six bits");
  chk_text_load: assert property (
    @(posedge clk) disable iff (rst)
    is_text |=> address_counter_q == $past(wr_data[6:0])
    && !glyph_sel_q)
    else $error("text address not loaded");
  // Shift pulses: direction, source and suppression
  chk_shift_dir: assert property (
    @(posedge clk) disable iff (rst)
    acc_shift |=> shift_pulse_q && shift_right_q != entry_q.inc)
    else $error("display shift direction wrong");
  chk_shift_move: assert property (
    @(posedge clk) disable iff (rst)
    is_shift |=> shift_pulse_q == $past(wr_data[did_pkg::B_SC])
    && shift_right_q == $past(wr_data[did_pkg::B_RL]))
    else $error("shift instruction not applied");
  chk_read_noshift: assert property (
    @(posedge clk) disable iff (rst)
    dat_rd |=> !shift_pulse_q)
    else $error("text read shifted display");
  chk_glyph_noshift: assert property (
    @(posedge clk) disable iff (rst)
    ram_acc && glyph_sel_q |=> !shift_pulse_q)
    else $error("glyph access shifted display");
  // Brightness byte handling
  chk_bright_cancel: assert property (
    @(posedge clk) disable iff (rst)
    cmd && !is_func |=> !bright_pend_q)
    else $error("brightness not cancelled");
  chk_bright_load: assert property (
    @(posedge clk) disable iff (rst)
    is_bright |=> bright_q == $past(wr_data[1:0]))
    else $error("brightness not loaded");
  chk_bright_keep: assert property (
    @(posedge clk) disable iff (rst)
    !is_bright |=> $stable(bright_q))
    else $error("brightness changed without data byte");
  // Busy window, converter and blink gating
  chk_busy_hold: assert property (
    @(posedge clk) disable iff (rst)
    take |=> !idle [*8])
    else $error("busy not held");
  chk_busy_refuse: assert property (
    @(posedge clk) disable iff (rst)
    !idle |=> $stable(disp_q) && $stable(address_counter_q))
    else $error("byte taken while busy");
  chk_conv_follow: assert property (
    @(posedge clk) disable iff (rst)
    !disp_q.disp_on |=> !conv_en_q)
    else $error("converter on with display off");
  chk_blink_gate: assert property (
    @(posedge clk) disable iff (rst)
    !disp_q.blink_on |=> !blink_all_q)
    else $error("cursor cell lit with blink off");

endmodule : did_decoder

// *** tb/did_host_model.sv ***
// Host processor model that drives the decoder's byte port.
// Assumes status_q reports busy in bit 7 from the cycle after acceptance.
`timescale 1ns/1ps
module did_host_model (
  // Clock and status
  input wire logic clk,
  input wire logic [7:0] status_q,
  // Host byte port
  output logic wr_stb,
  output logic rd_stb,
  output logic register_select,
  output logic [7:0] wr_data
);
  // ------------------------------------------------------------
  // Idle levels at time zero
  // ------------------------------------------------------------
  initial begin
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    register_select = 1'b0;
    wr_data = 8'h00;
  end

  // One whole byte per access, never split into nibbles
  // Byte width is always eight, as a serial host must use
  task automatic access(input logic rd, input logic rs,
                        input logic [7:0] d, input logic wait_rdy);
    int n;
    @(posedge clk);
    #1;
    wr_stb = ~rd;
    rd_stb = rd;
    register_select = rs;
    wr_data = d;
    @(posedge clk);
    #1;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    // Released lines show the inverse, so a stale value cannot pass
    register_select = ~rs;
    wr_data = ~d;
    n = 0;
    // Poll busy with a bound; a hang is left to the watchdog
    while (wait_rdy && n < 200 && (n < 1 || status_q[7] !== 1'b0)) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : access
endmodule : did_host_model

// *** tb/display_instruction_decoder_tb_top.sv ***
// Self-checking bench for the display instruction decoder.
// Assumes the host model polls busy after each request, except the unpolled 8'h0C access.
`timescale 1ns/1ps
module display_instruction_decoder_tb_top;
  logic clk, rst, wr_stb, rd_stb, register_select;
  logic [7:0] wr_data, status_q;
  did_pkg::did_disp_t disp_q;
  logic conv_en_q, blink_all_q, bus8_q, glyph_sel_q;
  logic shift_pulse_q, shift_right_q, ram_wr_q, ram_rd_q;
  logic [1:0] bright_q;
  logic [6:0] address_counter_q;
  int n_mismatch, check_count, n_shift, n_wr, n_rd, s0;
  logic last_right;
  logic [7:0] ea, d;

  did_decoder u_dut (.clk(clk), .rst(rst), .wr_stb(wr_stb),
    .register_select(register_select), .wr_data(wr_data),
    .rd_stb(rd_stb), .status_q(status_q), .disp_q(disp_q),
    .conv_en_q(conv_en_q), .blink_all_q(blink_all_q),
    .bright_q(bright_q), .bus8_q(bus8_q),
    .address_counter_q(address_counter_q), .glyph_sel_q(glyph_sel_q),
    .shift_pulse_q(shift_pulse_q), .shift_right_q(shift_right_q),
    .ram_wr_q(ram_wr_q), .ram_rd_q(ram_rd_q));
  did_host_model u_host (.clk(clk), .status_q(status_q), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .register_select(register_select),
    .wr_data(wr_data));

  // ------------------------------------------------------------
  // Clock, pulse counters and watchdog
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (shift_pulse_q === 1'b1) begin
      n_shift++;
      last_right = shift_right_q;
    end
    if (ram_wr_q === 1'b1) n_wr++;
    if (ram_rd_q === 1'b1) n_rd++;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end

  // ------------------------------------------------------------
  // Access and compare tasks
  // ------------------------------------------------------------
  task automatic ins(input logic [7:0] v);
    u_host.access(1'b0, 1'b0, v, 1'b1);
  endtask : ins
  task automatic dat(input logic [7:0] v);
    u_host.access(1'b0, 1'b1, v, 1'b1);
  endtask : dat
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    rst = 1'b1;
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    chk("bus8", 8'h01, {7'h00, bus8_q});
    chk("status", 8'h00, status_q);
    // Function set goes first
    ins(8'h30);
    chk("bus8", 8'h01, {7'h00, bus8_q});
    for (int c = 0; c < 4; c++) begin
      ins(8'h3F);
      dat(8'hFC | 8'(c));
      chk("bright", 8'(c), {6'h00, bright_q});
    end
    chk("wr_cnt", 8'h00, 8'(n_wr));
    ins(8'h30);
    ins(8'h08);
    dat(8'h01);
    chk("bright", 8'h03, {6'h00, bright_q});
    $display("test function_set done");
    for (int i = 8; i < 16; i++) begin
      ins(8'(i));
      chk("disp", 8'(i) & 8'h07, {5'h00, disp_q});
      chk("conv", {7'h00, i[2]}, {7'h00, conv_en_q});
      chk("blink", 8'h00, {7'h00, blink_all_q});
    end
    u_host.access(1'b0, 1'b0, 8'h0C, 1'b0);
    chk("busy", 8'h01, {7'h00, status_q[7]});
    ins(8'h08);
    chk("disp", 8'h04, {5'h00, disp_q});
    $display("test display_control done");
    ins(8'h06);
    ins(8'h7F);
    chk("status", 8'h3F, status_q);
    chk("glyph", 8'h01, {7'h00, glyph_sel_q});
    s0 = n_shift;
    dat(8'h11);
    chk("ac", 8'h00, {1'b0, address_counter_q});
    ins(8'h07);
    dat(8'h12);
    u_host.access(1'b1, 1'b1, 8'h00, 1'b1);
    chk("ac", 8'h02, {1'b0, address_counter_q});
    chk("shifts", 8'(s0), 8'(n_shift));
    $display("test glyph_ram done");
    ins(8'hC0);
    chk("glyph", 8'h00, {7'h00, glyph_sel_q});
    s0 = n_shift;
    dat(8'h41);
    chk("right", 8'h00, {7'h00, last_right});
    u_host.access(1'b1, 1'b1, 8'h00, 1'b1);
    chk("rd_cnt", 8'h02, 8'(n_rd));
    chk("shifts", 8'(s0 + 1), 8'(n_shift));
    ins(8'h05);
    dat(8'h42);
    chk("right", 8'h01, {7'h00, last_right});
    ins(8'h04);
    dat(8'h43);
    chk("shifts", 8'(s0 + 2), 8'(n_shift));
    chk("ac", 8'h40, {1'b0, address_counter_q});
    chk("wr_cnt", 8'h06, 8'(n_wr));
    $display("test text_ram done");
    ea = 8'h40;
    for (int k = 0; k < 4; k++) begin
      d = (k == 0) ? 8'h10 : (k == 1) ? 8'h17 : (k == 2) ? 8'h1A : 8'h1C;
      s0 = n_shift;
      ins(d);
      ea = d[2] ? ea + 8'h01 : ea - 8'h01;
      chk("shifts", 8'(s0) + {7'h00, d[3]}, 8'(n_shift));
      chk("ac", ea, {1'b0, address_counter_q});
      if (d[3]) chk("right", {7'h00, d[2]}, {7'h00, last_right});
    end
    // Four-bit width last, so no whole byte follows it
    ins(8'h20);
    chk("bus8", 8'h00, {7'h00, bus8_q});
    $display("test shift done");
    print_verdict();
  end
endmodule : display_instruction_decoder_tb_top
